// [tps_pin_select.sv]
// Purpose: pin function select for ch3 pin C and ch4 pins A and B
// Assumes: counter and general registers sit outside; match is a pulse
// Notes: registers on a plain port, read data one cycle after the strobe
`timescale 1ns/1ps

module tps_pin_select #(
   parameter int CW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire tps_pkg::tps_req_s req,
   output logic [7:0] rdata,
   // Counter and compare interface
   input wire logic [CW-1:0] counter,
   input wire logic [2:0] cmp_match,
   output logic [2:0] cmp_event,
   output logic [2:0] cap_strobe,
   output logic [CW-1:0] cap_value,
   // Pins
   input wire logic [2:0] pin_in,
   output tps_pkg::tps_pin_s pin
);
   import tps_pkg::*;

   logic [7:0] ch4_fn_r;
   logic [7:0] ch3_fn_r;
   logic [7:0] mode_r;
   logic [2:0] written_r;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] prev_r;
   logic [2:0] lvl_r;
   logic [2:0] oe_r;
   logic [2:0] cmp_event_r;
   logic [2:0] cap_strobe_r;
   logic [CW-1:0] cap_value_r;
   logic [7:0] rdata_r;
   logic [3:0] fn [TPS_CH];
   logic [2:0] buffered;
   logic [2:0] fn_wr;
   logic [2:0] cap_hit;

   // True when a field selects input capture
   function automatic logic is_capture(input logic [3:0] f);
      return f[TPS_BIT_CAPTURE];
   endfunction

   // Capture edge qualifier for one field
   function automatic logic cap_edge(input logic [3:0] f,
                                     input logic rise, input logic fall);
      if (f[TPS_BIT_BOTH]) begin
         return rise | fall;
      end else if (f[TPS_BIT_FALL]) begin
         return fall;
      end else begin
         return rise;
      end
   endfunction

   // Write decode for the two pin-function registers
   wire wr_ch4 = req.wr && (req.addr == TPS_OFF_CH4_FN_HIGH);
   wire wr_ch3 = req.wr && (req.addr == TPS_OFF_CH3_FN_LOW);

   assign fn[0] = ch4_fn_r[TPS_POS_CH4_A +: 4];
   assign fn[1] = ch4_fn_r[TPS_POS_CH4_B +: 4];
   assign fn[2] = ch3_fn_r[TPS_POS_CH3_C +: 4];
   // Pair B/D buffering is only stored: none of these pins belongs to it
   // buffer pair gating
   assign buffered = {mode_r[TPS_POS_BUF_AC], 2'b00};
   assign fn_wr = {wr_ch3, wr_ch4, wr_ch4};

   // Configuration registers
   always_ff @(posedge clk) begin
      if (reset) begin
         ch4_fn_r <= TPS_RST_FN;
         ch3_fn_r <= TPS_RST_FN;
         mode_r <= TPS_RST_MODE;
      end else if (req.wr) begin
         if (req.addr == TPS_OFF_CH4_FN_HIGH) begin
            ch4_fn_r <= req.wdata;
         end else if (req.addr == TPS_OFF_CH3_FN_LOW) begin
            ch3_fn_r <= req.wdata;
         end else if (req.addr == TPS_OFF_CH3_MODE) begin
            mode_r <= req.wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         written_r <= 3'h0;
      end else begin
         written_r <= written_r | fn_wr;
      end
   end

   // Two-stage synchroniser, then an edge history stage
   // The history stage costs a cycle but keeps sync1_r out of all logic
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         prev_r <= 3'h0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < TPS_CH; g++) begin : g_ch
         wire [3:0] wf = (g == 2) ? req.wdata[TPS_POS_CH3_C +: 4]
                       : (g == 1) ? req.wdata[TPS_POS_CH4_B +: 4]
                       : req.wdata[TPS_POS_CH4_A +: 4];
         wire rise = sync2_r[g] & ~prev_r[g];
         wire fall = ~sync2_r[g] & prev_r[g];
         wire out_mode = written_r[g] & ~is_capture(fn[g]);
         tps_act_e act;
         assign act = tps_act_e'(fn[g][1:0]);

         assign cap_hit[g] = written_r[g] & is_capture(fn[g]) & ~buffered[g]
                           & cap_edge(fn[g], rise, fall);

         // A field write in the same cycle as a match wins; the level skips that match, but cmp_event still reports it
         // Hold codes leave the level alone, so an unwritten pin stays low
         // Pin level and drive
         always_ff @(posedge clk) begin
            if (reset) begin
               // low and driven out of reset
               lvl_r[g] <= 1'b0;
               oe_r[g] <= 1'b1;
            end else if (fn_wr[g]) begin
               oe_r[g] <= ~wf[TPS_BIT_CAPTURE];
               // hold codes keep the present level
               if (!wf[TPS_BIT_CAPTURE] && wf[1:0] != TPS_ACT_HOLD) begin
                  lvl_r[g] <= wf[TPS_BIT_INIT];
               end
            end else if (out_mode && !buffered[g] && cmp_match[g]) begin
               case (act)
                  TPS_ACT_LOW: lvl_r[g] <= 1'b0;
                  TPS_ACT_HIGH: lvl_r[g] <= 1'b1;
                  TPS_ACT_TOGGLE: lvl_r[g] <= ~lvl_r[g];
                  default: lvl_r[g] <= lvl_r[g];
               endcase
            end
         end

         // compare event, also for hold codes
         always_ff @(posedge clk) begin
            if (reset) begin
               cmp_event_r[g] <= 1'b0;
            end else begin
               cmp_event_r[g] <= out_mode & ~buffered[g] & cmp_match[g];
            end
         end
      end
   endgenerate

   // One shared copy register: captures on two pins at once see one count
   // Software tells the channels apart by cap_strobe; cap_value then holds
   // capture strobe and counter copy
   always_ff @(posedge clk) begin
      if (reset) begin
         cap_strobe_r <= 3'h0;
         cap_value_r <= '0;
      end else begin
         cap_strobe_r <= cap_hit;
         if (|cap_hit) begin
            cap_value_r <= counter;
         end
      end
   end

   // Idle cycles return zero so stale data never sits on the bus
   // Status: [2:0] driven levels, [6:4] synchronised pin inputs
   // Read port; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= 8'h00;
      end else if (req.rd) begin
         if (req.addr == TPS_OFF_CH4_FN_HIGH) begin
            rdata_r <= ch4_fn_r;
         end else if (req.addr == TPS_OFF_CH3_FN_LOW) begin
            rdata_r <= ch3_fn_r;
         end else if (req.addr == TPS_OFF_CH3_MODE) begin
            rdata_r <= mode_r;
         end else if (req.addr == TPS_OFF_PIN_STATUS) begin
            rdata_r <= {1'b0, sync2_r, 1'b0, lvl_r};
         end else begin
            rdata_r <= 8'h00;
         end
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign rdata = rdata_r;
   assign cmp_event = cmp_event_r;
   assign cap_strobe = cap_strobe_r;
   assign cap_value = cap_value_r;
   assign pin.out = lvl_r;
   assign pin.oe = oe_r;
endmodule // tps_pin_select

// [tps_pkg.sv]
// Purpose: shared constants and types for the timer pin function select
// Assumes: 8-bit register port, three pin channels, 16-bit counter
// Notes: channel 0 = ch4 pin A, 1 = ch4 pin B, 2 = ch3 pin C
package tps_pkg;
   localparam int TPS_CH = 3;
   localparam int TPS_AW = 4;
   localparam int TPS_DW = 8;
   localparam int TPS_CW = 16;
   // Register offsets
   localparam logic [3:0] TPS_OFF_CH4_FN_HIGH = 4'h0;
   localparam logic [3:0] TPS_OFF_CH3_FN_LOW = 4'h1;
   localparam logic [3:0] TPS_OFF_CH3_MODE = 4'h2;
   localparam logic [3:0] TPS_OFF_PIN_STATUS = 4'h3;
   // Reset values
   localparam logic [7:0] TPS_RST_FN = 8'h00;
   localparam logic [7:0] TPS_RST_MODE = 8'h00;
   // Field positions
   localparam int TPS_POS_CH4_A = 0;
   localparam int TPS_POS_CH4_B = 4;
   localparam int TPS_POS_CH3_C = 0;
   localparam int TPS_POS_BUF_AC = 4;
   localparam int TPS_POS_BUF_BD = 5;
   localparam int TPS_POS_IN_LVL = 4;
   // Pin-function field bits
   localparam int TPS_BIT_CAPTURE = 3;
   localparam int TPS_BIT_INIT = 2;
   localparam int TPS_BIT_BOTH = 1;
   localparam int TPS_BIT_FALL = 0;

   // Compare-match action, low two bits of the field
   typedef enum logic [1:0] {
      TPS_ACT_HOLD = 2'b00,
      TPS_ACT_LOW = 2'b01,
      TPS_ACT_HIGH = 2'b10,
      TPS_ACT_TOGGLE = 2'b11
   } tps_act_e;

   // Register port request
   typedef struct packed {
      logic [TPS_AW-1:0] addr;
      logic [TPS_DW-1:0] wdata;
      logic wr;
      logic rd;
   } tps_req_s;

   // Two-way pin drive
   typedef struct packed {
      logic [TPS_CH-1:0] out;
      logic [TPS_CH-1:0] oe;
   } tps_pin_s;
endpackage

// [tps_pin_select_monitor.sv]
// Purpose: port assertions for tps_pin_select
// Assumes: channel A of ch4 stands in for all three, except the buffer check on ch3 pin C
// Notes: field A and buffer bit tracked from port writes
`timescale 1ns/1ps
module tps_pin_select_monitor #(
   parameter int CW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port and timer
   input wire tps_pkg::tps_req_s req,
   input wire logic [CW-1:0] counter,
   input wire logic [2:0] cmp_match,
   input wire logic [2:0] cmp_event,
   input wire logic [2:0] cap_strobe,
   input wire logic [CW-1:0] cap_value,
   // Pins
   input wire logic [2:0] pin_in,
   input wire tps_pkg::tps_pin_s pin
);
   import tps_pkg::*;
   logic [3:0] fa_r;
   logic wa_r, bf_r, nw, oc;
   // A field write wins over a match in the same cycle
   assign nw = !(req.wr && req.addr == TPS_OFF_CH4_FN_HIGH);
   assign oc = wa_r && !fa_r[3] && cmp_match[0] && nw;
   always_ff @(posedge clk) begin
      if (reset) begin
         fa_r <= 4'h0;
         wa_r <= 1'b0;
      end else if (!nw) begin
         fa_r <= req.wdata[3:0];
         wa_r <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (reset)
         bf_r <= 1'b0;
      else if (req.wr && req.addr == TPS_OFF_CH3_MODE)
         bf_r <= req.wdata[TPS_POS_BUF_AC];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_drive_low: assert property (oc && fa_r[1:0] == 2'b01 |=>
      !pin.out[0]) else $error("pin not driven low");
   a_drive_high: assert property (oc && fa_r[1:0] == 2'b10 |=>
      pin.out[0]) else $error("pin not driven high");
   a_toggle_pin: assert property (oc && fa_r[1:0] == 2'b11 |=>
      pin.out[0] != $past(pin.out[0])) else $error("pin not toggled");
   a_hold_event: assert property (oc && fa_r[1:0] == 2'b00 |=>
      cmp_event[0] && $stable(pin.out[0])) else $error("hold wrong");
   a_rise_cap: assert property (wa_r && fa_r[3] &&
      fa_r[1:0] == 2'b00 && $rose(pin_in[0]) |-> ##[2:4] cap_strobe[0])
      else $error("no capture");
   a_low_hold: assert property (!wa_r |-> !pin.out[0])
      else $error("pin not held low");
   a_buf_quiet: assert property (bf_r [*4] |-> !cmp_event[2]
      && !cap_strobe[2]) else $error("buffered channel active");
   a_cap_value: assert property (cap_strobe[0] |->
      cap_value == $past(counter)) else $error("capture value wrong");
endmodule // tps_pin_select_monitor

bind tps_pin_select tps_pin_select_monitor #(.CW(CW)) mon (.clk, .reset,
   .req, .counter, .cmp_match, .cmp_event, .cap_strobe, .cap_value, .pin_in,
   .pin);

// [tps_pin_ext.sv]
// Purpose: far-side circuit on the three timer pins
// Assumes: no pulls; a released pin follows the outside source
// Notes: while the device drives, the pin reads back its own level
`timescale 1ns/1ps
module tps_pin_ext (
   // Device drive
   input wire logic [2:0] out,
   input wire logic [2:0] oe,
   // Outside source and resolved level
   input wire logic [2:0] ext,
   output logic [2:0] lvl
);
   assign lvl = (oe & out) | (~oe & ext);
endmodule // tps_pin_ext

// [tps_pin_select_test.sv]
// Purpose: self-checking bench for tps_pin_select
// Assumes: all output codes on all pins, capture on ch4 pins A and B and ch3 pin C
// Notes: counter runs free so captured values are predictable
`timescale 1ns/1ps
module tps_pin_select_test;
   import tps_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   tps_req_s req = '0;
   logic [7:0] rdata;
   logic [15:0] counter = 16'h0, cap_value;
   logic [2:0] cmp_match = 3'h0, ext = 3'h0, cmp_event, cap_strobe, pin_in;
   tps_pin_s pin;
   int err_count = 0, checks = 0;
   always #20 clk = ~clk;
   always @(posedge clk) counter <= counter + 16'h1;
   tps_pin_select dut (.clk, .reset, .req, .rdata, .counter, .cmp_match,
      .cmp_event, .cap_strobe, .cap_value, .pin_in, .pin);
   tps_pin_ext far (.out(pin.out), .oe(pin.oe), .ext(ext), .lvl(pin_in));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One write or read; a read compares the data in the following cycle
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= {a, d, w, !w};
      @(posedge clk);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      #1;
      if (!w)
         chk(rdata, d);
   endtask
   task mt(input logic [2:0] m);
      @(posedge clk);
      cmp_match <= m;
      @(posedge clk);
      cmp_match <= 3'h0;
      #1;
   endtask
   task pe(input int k, input logic v, input logic e);
      logic s;
      s = 1'b0;
      @(posedge clk);
      ext[k] <= v;
      repeat (6) begin
         @(posedge clk);
         #1;
         if (cap_strobe[k] === 1'b1) begin
            s = 1'b1;
            chk(cap_value, counter - 16'h1);
         end
      end
      chk(s, e);
   endtask
   task t_reset;
      chk(pin, 6'h07);
      mt(3'h7);
      chk({cmp_event, pin.out}, 6'h0);
      bus(1'b0, 4'h0, TPS_RST_FN);
      bus(1'b0, 4'h2, TPS_RST_MODE);
      bus(1'b1, 4'hf, 8'hff);
      bus(1'b0, 4'hf, 8'h00);
      $display("t_reset end");
   endtask
   task t_out;
      logic l;
      l = 1'b0;
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 4'h0, {2{c[3:0]}});
         bus(1'b1, 4'h1, {4'h0, c[3:0]});
         if (c[1:0] != 2'b00)
            l = c[2];
         chk(pin.out, {3{l}});
         mt(3'h7);
         if (c[1:0] == 2'b11)
            l = ~l;
         else if (c[1:0] != 2'b00)
            l = c[1];
         chk({cmp_event, pin.out}, {3'h7, {3{l}}});
      end
      bus(1'b0, 4'h0, 8'h77);
      $display("t_out end");
   endtask
   task t_cap;
      bus(1'b1, 4'h0, 8'h98);
      chk(pin.oe[1:0], 2'b00);
      pe(0, 1'b1, 1'b1);
      pe(0, 1'b0, 1'b0);
      pe(1, 1'b1, 1'b0);
      pe(1, 1'b0, 1'b1);
      bus(1'b1, 4'h0, 8'h09);
      pe(0, 1'b1, 1'b0);
      pe(0, 1'b0, 1'b1);
      bus(1'b1, 4'h0, 8'h0b);
      pe(0, 1'b1, 1'b1);
      pe(0, 1'b0, 1'b1);
      bus(1'b1, 4'h0, 8'h0c);
      pe(0, 1'b1, 1'b1);
      $display("t_cap end");
   endtask
   task t_buf;
      bus(1'b1, 4'h2, 8'h10);
      bus(1'b0, 4'h2, 8'h10);
      bus(1'b1, 4'h1, 8'h03);
      mt(3'h4);
      chk({cmp_event[2], pin.out[2]}, 2'b00);
      bus(1'b1, 4'h1, 8'h0b);
      bus(1'b0, 4'h1, 8'h0b);
      pe(2, 1'b1, 1'b0);
      bus(1'b1, 4'h2, 8'h00);
      pe(2, 1'b0, 1'b1);
      bus(1'b0, 4'h3, 8'h10);
      $display("t_buf end");
   endtask
   // Mid-run reset must bring back the low hold on every pin
   task t_rst;
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk(pin, 6'h07);
      mt(3'h7);
      chk({cmp_event, pin.out}, 6'h0);
      $display("t_rst end");
   endtask
   task conclude;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_out;
      t_cap;
      t_buf;
      t_rst;
      conclude;
   end
   // The tests need well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      conclude;
   end
endmodule // tps_pin_select_test
